// ---- src/twoeu_core.sv ----
// order execution and arithmetic unit of a 40-bit two-order word machine
module twoeu_core
  import twoeu_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // memory port
  output logic                   memReq,
  output logic                   memWe,
  output logic [ADDR_W-1:0]      memAddr,
  output logic [WORD_W-1:0]      memWdata,
  input  wire logic [WORD_W-1:0] memRdata,
  input  wire logic              memAck,
  // visible state
  output logic [WORD_W-1:0]      accumulator_register,
  output logic [WORD_W-1:0]      quotient_register,
  output logic [ADDR_W-1:0]      progCounter,
  output logic                   rightHalf
);

  // ==========================================================
  // decode helpers
  // pick one order out of a word; called only to form the current order
  function automatic logic [ORDER_W-1:0] orderOf(input logic [WORD_W-1:0] w, input logic right);
    orderOf = right ? w[ORDER_W-1:0] : w[WORD_W-1:ORDER_W];
  endfunction : orderOf

  twoeu_state_type        state;
  twoeu_state_type        next_state;
  logic [WORD_W-1:0]      instr;
  logic [WORD_W-1:0]      next_instr;
  logic [WORD_W-1:0]      next_acc;
  logic [WORD_W-1:0]      next_quo;
  logic [ADDR_W-1:0]      next_pc;
  logic                   next_right;
  logic                   next_memReq;
  logic                   next_memWe;
  logic [ADDR_W-1:0]      next_memAddr;
  logic [WORD_W-1:0]      next_memWdata;
  logic [ORDER_W-1:0]     curOrder;
  logic [OP_W-1:0]        curOp;
  logic [ADDR_W-1:0]      curAddr;

  assign curOrder = orderOf(instr, rightHalf);
  assign curOp    = curOrder[ORDER_W-1:ADDR_W];
  assign curAddr  = curOrder[ADDR_W-1:0];

  // ==========================================================
  // arithmetic datapath
  logic [WORD_W-1:0]      operand;
  logic [PROD_W-1:0]      product;
  logic [WORD_W-1:0]      prodHigh;
  logic [PROD_W-1:0]      dividend;
  logic [PROD_W-1:0]      quoWide;
  logic [PROD_W-1:0]      remWide;
  logic [WORD_W-1:0]      immVal;
  logic [2*WORD_W-1:0]    pairLeft;
  logic [2*WORD_W-1:0]    pairRight;

  // quotient register stands in as memory word 2048 for load and add
  assign operand  = (curAddr == QUO_ADDR) ? quotient_register : memRdata;
  // signed fractions: product has 78 magnitude bits below two sign bits
  assign product  = PROD_W'($signed(quotient_register) * $signed(memRdata));
  assign prodHigh = {product[2*FRAC_W], product[2*FRAC_W-1:FRAC_W]};
  // dividend scaled so the quotient comes out as a 39-bit fraction
  assign dividend = PROD_W'($signed(accumulator_register)) <<< FRAC_W;
  // a zero divisor yields a zero quotient instead of stalling the sequencer
  assign quoWide  = (memRdata == '0) ? '0 : PROD_W'($signed(dividend) / $signed(memRdata));
  assign remWide  = dividend - PROD_W'($signed(quoWide) * $signed(memRdata));
  assign immVal   = {curAddr, {IMM_SH{1'b0}}};
  // accumulator and quotient register form an 80-bit shift pair, quotient register on top for left shifts, accumulator on top for right shifts
  assign pairLeft  = {quotient_register, accumulator_register} << curAddr;
  assign pairRight = $signed({accumulator_register, quotient_register}) >>> curAddr;

  // ==========================================================
  // sequencer: next values
  always_comb begin
    next_state    = state;
    next_instr    = instr;
    next_acc      = accumulator_register;
    next_quo      = quotient_register;
    next_pc       = progCounter;
    next_right    = rightHalf;
    next_memReq   = memReq;
    next_memWe    = memWe;
    next_memAddr  = memAddr;
    next_memWdata = memWdata;
    unique case (state)
      ST_FETCH: begin
        next_memReq  = 1'b1;
        next_memWe   = 1'b0;
        next_memAddr = progCounter;
        if (memReq && memAck) begin
          next_memReq = 1'b0;
          next_instr  = memRdata;
          next_state  = ST_DECODE;
        end
      end
      ST_DECODE: begin
        // default successor; transfers override it
        if (rightHalf) begin
          next_pc    = progCounter + ADDR_ONE;
          next_right = 1'b0;
          next_state = ST_FETCH;
        end else begin
          next_right = 1'b1;
        end
        unique case (curOp)
          OP_LOAD, OP_ADD, OP_LDQ, OP_MULF, OP_MULR, OP_DIV,
          OP_SUBL, OP_SUBR, OP_HSL, OP_HSR: begin
            // operand or target word must be read first; 2048 skips memory for load and add only
            next_pc    = progCounter;
            next_right = rightHalf;
            if ((curOp == OP_LOAD || curOp == OP_ADD) && curAddr == QUO_ADDR) begin
              next_acc   = (curOp == OP_ADD) ? accumulator_register + operand : operand;
              next_pc    = rightHalf ? progCounter + ADDR_ONE : progCounter;
              next_right = !rightHalf;
              next_state = rightHalf ? ST_FETCH : ST_DECODE;
            end else begin
              next_state   = ST_READ;
              next_memReq  = 1'b1;
              next_memWe   = 1'b0;
              next_memAddr = curAddr;
            end
          end
          OP_STQ, OP_STA: begin
            next_pc       = progCounter;
            next_right    = rightHalf;
            next_state    = ST_WRITE;
            next_memReq   = 1'b1;
            next_memWe    = 1'b1;
            next_memAddr  = curAddr;
            next_memWdata = (curOp == OP_STQ) ? quotient_register : accumulator_register;
          end
          OP_TL, OP_TR, OP_CL, OP_CR: begin
            // conditional forms fall through to the default successor when negative
            if (curOp == OP_TL || curOp == OP_TR || !accumulator_register[WORD_W-1]) begin
              next_pc    = curAddr;
              next_right = (curOp == OP_TR || curOp == OP_CR);
              next_state = ST_FETCH;
            end
          end
          OP_SHL: begin
            next_quo = pairLeft[2*WORD_W-1:WORD_W];
            next_acc = pairLeft[WORD_W-1:0];
          end
          OP_SHR: begin
            next_acc = pairRight[2*WORD_W-1:WORD_W];
            next_quo = pairRight[WORD_W-1:0];
          end
          OP_IMMC: next_acc = immVal;
          OP_IMMA: next_acc = accumulator_register + immVal;
          default: ;  // unassigned codes act as no operation
        endcase
      end
      ST_READ: begin
        if (memAck) begin
          next_memReq = 1'b0;
          next_state  = ST_DECODE;
          next_pc     = rightHalf ? progCounter + ADDR_ONE : progCounter;
          next_right  = !rightHalf;
          if (rightHalf) begin
            next_state = ST_FETCH;
          end
          unique case (curOp)
            OP_LOAD: next_acc = operand;
            OP_ADD:  next_acc = accumulator_register + operand;
            OP_LDQ:  next_quo = memRdata;
            OP_MULR: next_acc = prodHigh + WORD_W'(product[FRAC_W-1]);
            OP_MULF: begin
              next_acc = prodHigh;
              next_quo = {1'b0, product[FRAC_W-1:0]};
            end
            OP_DIV: begin
              next_quo = quoWide[WORD_W-1:0];
              next_acc = {remWide[WORD_W-2:0], 1'b0};
            end
            default: begin
              // substitutions: patch the word just read, then write it back
              next_state    = ST_WRITE;
              next_pc       = progCounter;
              next_right    = rightHalf;
              next_memReq   = 1'b0;  // memory needs one idle cycle between accesses
              next_memWe    = 1'b1;
              next_memWdata = memRdata;
              unique case (curOp)
                OP_SUBL: next_memWdata[ORDER_W+ADDR_W-1:ORDER_W] =
                           accumulator_register[ORDER_W+ADDR_W-1:ORDER_W];
                OP_SUBR: next_memWdata[ADDR_W-1:0] = accumulator_register[ADDR_W-1:0];
                OP_HSL:  next_memWdata[WORD_W-1:ORDER_W] = accumulator_register[WORD_W-1:ORDER_W];
                default: next_memWdata[ORDER_W-1:0] = accumulator_register[ORDER_W-1:0];
              endcase
            end
          endcase
        end
      end
      ST_WRITE: begin
        // a write-back after its read raises the request only after the idle cycle
        next_memReq = 1'b1;
        if (memReq && memAck) begin
          next_memReq = 1'b0;
          next_memWe  = 1'b0;
          next_pc     = rightHalf ? progCounter + ADDR_ONE : progCounter;
          next_right  = !rightHalf;
          next_state  = rightHalf ? ST_FETCH : ST_DECODE;
        end
      end
      default: next_state = ST_FETCH;
    endcase
  end

  // sequencer: registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state                <= ST_FETCH;
      instr                <= '0;
      accumulator_register <= '0;
      quotient_register    <= '0;
      progCounter          <= RESET_PC;
      rightHalf            <= 1'b0;
      memReq               <= 1'b0;
      memWe                <= 1'b0;
      memAddr              <= '0;
      memWdata             <= '0;
    end else begin
      state                <= next_state;
      instr                <= next_instr;
      accumulator_register <= next_acc;
      quotient_register    <= next_quo;
      progCounter          <= next_pc;
      rightHalf            <= next_right;
      memReq               <= next_memReq;
      memWe                <= next_memWe;
      memAddr              <= next_memAddr;
      memWdata             <= next_memWdata;
    end
  end

  // ==========================================================
  // checks
  logic inDecode;
  logic readDone;
  assign inDecode = (state == ST_DECODE);
  assign readDone = (state == ST_READ) && memAck;

  a_ldq_overwrite: assert property (@(posedge clk_sys) disable iff (!rst_n)
    readDone && curOp == OP_LDQ |=> quotient_register == $past(memRdata))
    else $error("load-quotient did not overwrite quotient register");

  a_mulf_low_sign: assert property (@(posedge clk_sys) disable iff (!rst_n)
    readDone && curOp == OP_MULF |=> !quotient_register[WORD_W-1]
      && accumulator_register == $past(prodHigh))
    else $error("full multiply result misplaced");

  a_mul_zero_cand: assert property (@(posedge clk_sys) disable iff (!rst_n)
    readDone && curOp == OP_MULR && memRdata == '0 |=> accumulator_register == '0)
    else $error("multiply by zero word not zero");

  a_transfer_target: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inDecode && (curOp == OP_TL || curOp == OP_TR)
      |=> state == ST_FETCH && progCounter == $past(curAddr) && rightHalf == $past(curOp == OP_TR))
    else $error("transfer went to wrong order");

  a_cond_negative: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inDecode && !rightHalf && curOp == OP_CL && accumulator_register[WORD_W-1]
      |=> state == ST_DECODE && rightHalf && progCounter == $past(progCounter))
    else $error("negative conditional transfer was taken");

  a_store_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inDecode && curOp == OP_STA |=> memWe && memWdata == accumulator_register
      && accumulator_register == $past(accumulator_register))
    else $error("store data or source wrong");

  a_shift_forty: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inDecode && curOp == OP_SHL && curAddr == 12'h028
      |=> quotient_register == $past(accumulator_register) && accumulator_register == '0)
    else $error("left shift of 40 did not move accumulator");

  a_shift_right_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inDecode && curOp == OP_SHR && curAddr == ADDR_ONE
      |=> quotient_register[WORD_W-1] == $past(accumulator_register[0])
      && accumulator_register[WORD_W-1] == $past(accumulator_register[WORD_W-1]))
    else $error("right shift did not feed quotient top");

  a_imm_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inDecode && curOp == OP_IMMC |=> accumulator_register == {$past(curAddr), {IMM_SH{1'b0}}})
    else $error("immediate clear load wrong");

  a_sub_addr_left: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == ST_WRITE && memWe && curOp == OP_SUBL
      |-> memWdata[ORDER_W+ADDR_W-1:ORDER_W] == accumulator_register[ORDER_W+ADDR_W-1:ORDER_W])
    else $error("left address substitution wrong");

  a_right_advance: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inDecode && rightHalf && curOp == OP_SHL
      |=> state == ST_FETCH && !rightHalf && progCounter == $past(progCounter) + ADDR_ONE)
    else $error("right-half order did not advance to next word");

endmodule : twoeu_core

// ---- src/twoeu_pkg.sv ----
// constants of the two-order word execution unit
package twoeu_pkg;
  localparam int WORD_W  = 40;                 // machine word
  localparam int ORDER_W = 20;                 // one order, half a word
  localparam int ADDR_W  = 12;                 // address field
  localparam int OP_W    = 8;                  // operation code
  localparam int PROD_W  = 2 * WORD_W;         // full signed product width
  localparam int FRAC_W  = WORD_W - 1;         // magnitude bits of a fraction
  localparam int IMM_SH  = WORD_W - ADDR_W;    // immediate lands in top bits
  localparam logic [ADDR_W-1:0] QUO_ADDR = 12'h800;  // 2048 names the quotient register
  localparam logic [ADDR_W-1:0] ADDR_ONE = 12'h001;
  // 4-bit letters used to spell operation codes
  localparam logic [3:0] LET_A = 4'hA;
  localparam logic [3:0] LET_B = 4'hB;
  localparam logic [3:0] LET_C = 4'hC;
  localparam logic [3:0] LET_D = 4'hD;
  localparam logic [3:0] LET_E = 4'hE;
  localparam logic [3:0] LET_F = 4'hF;
  localparam logic [OP_W-1:0] OP_LOAD  = {LET_A, LET_A};  // memory to accumulator, clearing
  localparam logic [OP_W-1:0] OP_ADD   = {LET_B, LET_A};  // memory added to accumulator
  localparam logic [OP_W-1:0] OP_LDQ   = {LET_E, LET_B};  // memory to quotient register
  localparam logic [OP_W-1:0] OP_MULF  = {LET_D, LET_A};  // full product
  localparam logic [OP_W-1:0] OP_MULR  = {LET_D, LET_B};  // rounded product
  localparam logic [OP_W-1:0] OP_DIV   = {LET_D, LET_D};
  localparam logic [OP_W-1:0] OP_TL    = {LET_C, LET_A};
  localparam logic [OP_W-1:0] OP_TR    = {LET_C, LET_B};
  localparam logic [OP_W-1:0] OP_CL    = {LET_C, LET_C};
  localparam logic [OP_W-1:0] OP_CR    = {LET_C, LET_D};
  localparam logic [OP_W-1:0] OP_STQ   = {LET_E, LET_C};
  localparam logic [OP_W-1:0] OP_STA   = {LET_D, LET_C};
  localparam logic [OP_W-1:0] OP_SUBL  = {LET_F, LET_A};  // address of left order
  localparam logic [OP_W-1:0] OP_SUBR  = {LET_F, LET_B};  // address of right order
  localparam logic [OP_W-1:0] OP_HSL   = {LET_F, LET_C};  // substitute_left_half
  localparam logic [OP_W-1:0] OP_HSR   = {LET_F, LET_D};  // substitute_right_half
  localparam logic [OP_W-1:0] OP_SHR   = {LET_E, LET_E};  // shift_right_pair
  localparam logic [OP_W-1:0] OP_SHL   = {LET_D, LET_E};  // shift_left_pair
  localparam logic [OP_W-1:0] OP_IMMC  = {LET_E, LET_F};  // immediate_clear_load
  localparam logic [OP_W-1:0] OP_IMMA  = {LET_D, LET_F};  // immediate_add
  localparam logic [ADDR_W-1:0] RESET_PC = 12'h000;
  typedef enum logic [3:0] {
    ST_FETCH  = 4'b0001,
    ST_DECODE = 4'b0010,
    ST_READ   = 4'b0100,
    ST_WRITE  = 4'b1000
  } twoeu_state_type;
endpackage : twoeu_pkg

// ---- verification/twoeu_core_tb.sv ----
// self-checking bench: runs a small program and checks every memory write
module twoeu_core_tb
  import twoeu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  logic              clk_sys = 1'b0;
  logic              rst_n;
  logic              memReq;
  logic              memWe;
  logic [ADDR_W-1:0] memAddr;
  logic [WORD_W-1:0] memWdata;
  logic [WORD_W-1:0] memRdata;
  logic              memAck;
  logic [1:0]        memLatency;
  logic [WORD_W-1:0] accumulator_register;
  logic [WORD_W-1:0] quotient_register;
  logic [ADDR_W-1:0] progCounter;
  logic              rightHalf;
  logic [51:0]       expQ [$];
  logic [31:0]       seed;
  int                n_fail = 0;
  int                n_compared = 0;
  always #10 clk_sys = ~clk_sys;  // 50 MHz
  twoeu_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .accumulator_register(accumulator_register),
    .quotient_register(quotient_register), .progCounter(progCounter), .rightHalf(rightHalf));
  twoeu_mem_model mem_i (.clk_sys(clk_sys), .rst_n(rst_n), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .memLatency(memLatency));
  // ==========================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic get_rand(output logic [WORD_W-1:0] v);
    seed = xs(seed);
    v[39:32] = seed[7:0];
    seed = xs(seed);
    v[31:0] = seed;
  endtask : get_rand
  function automatic logic [WORD_W-1:0] wd(input logic [7:0] opl, input logic [11:0] al,
                                            input logic [7:0] opr, input logic [11:0] ar);
    return {opl, al, opr, ar};
  endfunction : wd
  task automatic note(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    expQ.push_back({a, d});
  endtask : note
  task automatic check_write(input logic [ADDR_W-1:0] ea, input logic [ADDR_W-1:0] ga,
                             input logic [WORD_W-1:0] ed, input logic [WORD_W-1:0] gd);
    n_compared++;
    if (ga !== ea || gd !== ed) begin
      n_fail++;
      $display("Error at %0t: write exp %h:%h got %h:%h", $time, ea, ed, ga, gd);
    end
  endtask : check_write
  task automatic check_reg(input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: register exp %h got %h", $time, e, g);
    end
  endtask : check_reg
  task automatic report_and_stop;
    $display("TB: compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // memory latency varies every cycle so both prompt and slow answers occur
  always @(posedge clk_sys) begin
    #1 memLatency = seed[1:0];
    seed = xs(seed);
  end
  // write monitor: each completed write takes the oldest note
  always @(posedge clk_sys) begin
    logic [51:0] e;
    if (rst_n && memReq && memWe && memAck) begin
      if (expQ.size() == 0) begin
        n_compared++;
        n_fail++;
        $display("Error at %0t: stray write %h data %h", $time, memAddr, memWdata);
      end else begin
        e = expQ.pop_front();
        check_write(e[51:40], memAddr, e[39:0], memWdata);
      end
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    logic [WORD_W-1:0] r1, ra, rb, r3, r4, r5, r6, a2;
    logic signed [WORD_W-1:0] sa, sb;
    logic signed [PROD_W-1:0] p;
    rst_n = 1'b0;
    memLatency = 2'h0;
    seed = 32'h6072;
    get_rand(r1); get_rand(ra); get_rand(rb); get_rand(r3); get_rand(r4); get_rand(r5); get_rand(r6);
    for (int i = 0; i < 128; i++) mem_i.mem[i] = 40'h0;
    mem_i.mem[0]  = wd(OP_LDQ, 12'h032, OP_STQ, 12'h03C);
    mem_i.mem[1]  = wd(OP_IMMC, 12'h123, OP_IMMA, 12'h001);
    mem_i.mem[2]  = wd(OP_STA, 12'h03D, OP_SHL, 12'h028);
    mem_i.mem[3]  = wd(OP_STQ, 12'h03E, OP_STA, 12'h03F);
    mem_i.mem[4]  = wd(OP_LDQ, 12'h033, OP_MULF, 12'h034);
    mem_i.mem[5]  = wd(OP_STA, 12'h040, OP_STQ, 12'h041);
    mem_i.mem[6]  = wd(OP_LDQ, 12'h033, OP_MULR, 12'h034);
    mem_i.mem[7]  = wd(OP_STA, 12'h042, OP_TR, 12'h009);
    mem_i.mem[8]  = wd(OP_STA, 12'h063, OP_STA, 12'h063);  // reached only by a wrong jump
    mem_i.mem[9]  = wd(OP_STA, 12'h063, OP_IMMC, 12'h800);
    mem_i.mem[10] = wd(OP_CL, 12'h008, OP_IMMC, 12'h7FF);
    mem_i.mem[11] = wd(OP_SHR, 12'h008, OP_CL, 12'h00D);
    mem_i.mem[12] = wd(OP_STA, 12'h063, OP_STA, 12'h063);
    mem_i.mem[13] = wd(OP_SUBL, 12'h046, OP_SUBR, 12'h047);
    mem_i.mem[14] = wd(OP_HSL, 12'h048, OP_HSR, 12'h049);
    mem_i.mem[15] = wd(OP_IMMC, 12'h100, OP_DIV, 12'h035);
    mem_i.mem[16] = wd(OP_STQ, 12'h04A, OP_STA, 12'h04B);
    mem_i.mem[17] = wd(OP_LOAD, QUO_ADDR, OP_ADD, QUO_ADDR);
    mem_i.mem[18] = wd(OP_STA, 12'h04C, OP_TL, 12'h013);
    mem_i.mem[19] = wd(OP_MULR, 12'h036, OP_STA, 12'h04D);  // word 54 is zero
    mem_i.mem[20] = wd(OP_SHR, ADDR_ONE, OP_TL, 12'h014);  // parking loop
    mem_i.mem[50] = r1;
    mem_i.mem[51] = ra;
    mem_i.mem[52] = rb;
    mem_i.mem[53] = 40'h4000000000;  // one half
    mem_i.mem[70] = r3;
    mem_i.mem[71] = r4;
    mem_i.mem[72] = r5;
    mem_i.mem[73] = r6;
    sa = ra;
    sb = rb;
    p = sa * sb;
    a2 = 40'h007FF00000;  // 7FF at the top, shifted right eight places
    note(12'h03C, r1);
    note(12'h03D, 40'h1240000000);
    note(12'h03E, 40'h1240000000);
    note(12'h03F, 40'h0);
    note(12'h040, p[78:39]);
    note(12'h041, {1'b0, p[38:0]});
    note(12'h042, p[78:39] + {39'h0, p[38]});
    note(12'h046, {r3[39:32], a2[31:20], r3[19:0]});
    note(12'h047, {r4[39:12], a2[11:0]});
    note(12'h048, {a2[39:20], r5[19:0]});
    note(12'h049, {r6[39:20], a2[19:0]});
    note(12'h04A, 40'h2000000000);
    note(12'h04B, 40'h0);
    note(12'h04C, 40'h4000000000);
    note(12'h04D, 40'h0);
    repeat (6) @(posedge clk_sys);
    #1;
    check_reg(40'h0, accumulator_register);
    check_reg(40'h0, {28'h0, progCounter});
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 8000 && expQ.size() != 0; i++) @(posedge clk_sys);
    if (expQ.size() != 0) begin
      n_fail++;
      $display("Error at %0t: timeout, %h writes missing", $time, expQ.size());
    end
    repeat (100) @(posedge clk_sys);
    #1;
    check_reg(40'h14, {28'h0, progCounter});
    report_and_stop();
  end
endmodule : twoeu_core_tb

// ---- verification/twoeu_mem_model.sv ----
// word-addressed memory partner holding program and data for the execution unit
module twoeu_mem_model
  import twoeu_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // memory port
  input  wire logic              memReq,
  input  wire logic              memWe,
  input  wire logic [ADDR_W-1:0] memAddr,
  input  wire logic [WORD_W-1:0] memWdata,
  output logic [WORD_W-1:0]      memRdata,
  output logic                   memAck,
  // wait states chosen by the bench, 0 to 3
  input  wire logic [1:0]        memLatency
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // storage and answer logic
  logic [WORD_W-1:0] mem [0:127];
  logic [1:0]        waitCnt;
  logic              served;
  // one ack per request; read data lives only in the ack cycle
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      memAck   <= 1'b0;
      served   <= 1'b0;
      waitCnt  <= 2'h0;
      memRdata <= 40'h5555555555;
    end else begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata;  // stale data never lingers on the bus
      if (!memReq) begin
        served  <= 1'b0;
        waitCnt <= 2'h0;
      end else if (!served) begin
        if (waitCnt >= memLatency) begin
          memAck   <= 1'b1;
          served   <= 1'b1;
          memRdata <= mem[memAddr[6:0]];
          if (memWe) mem[memAddr[6:0]] <= memWdata;
        end else begin
          waitCnt <= waitCnt + 2'h1;
        end
      end
    end
  end
endmodule : twoeu_mem_model
